// ### hmad_chk_asserts.sv
/* port properties of hmad_decoder.
   assumes: bound to the decoder from tb; one clock, sync reset. */
`timescale 1ns/1ps
module hmad_chk
  import hmad_pkg::*;
(
  input wire logic         clk,
  input wire logic         rst,
  input wire logic         req_valid,
  input wire logic [35:0]  req_addr,
  input wire logic         req_write,
  input wire logic         req_from_pci,
  input wire logic         system_management_state,
  input wire logic         cfg_wr,
  input wire logic [7:0]   cfg_addr,
  input wire logic [7:0]   cfg_wdata,
  input wire logic         rsp_valid,
  input wire hmad_target_e rsp_target,
  input wire logic [35:0]  rsp_addr,
  input wire logic         rsp_cacheable,
  input wire logic         rsp_zero_data,
  input wire logic         rsp_drop_write
);
  // ==========================================================================
  // helper: registers are not visible at ports, so mirror the high-ram enable
  logic hi_r;
  logic lo;
  logic cpu_lo;
  assign lo = req_valid && req_addr >= 36'h0000a0000 && req_addr <= 36'h0000bffff;
  assign cpu_lo = lo && !req_from_pci && system_management_state;
  always_ff @(posedge clk) begin
    if (rst) hi_r <= 1'b0;
    else if (cfg_wr && cfg_addr == 8'h73) hi_r <= cfg_wdata[7];
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================================================
  // decode properties
  AST_BIOS: assert property (req_valid && req_addr[35:21] == 15'h7ff
    |=> rsp_target == HMAD_TGT_BIOS) else $error("bios miss");
  AST_RST: assert property (disable iff (1'b0) rst
    |=> !rsp_valid && rsp_target == HMAD_TGT_NONE) else $error("reset state");
  AST_IOIC: assert property (req_valid && req_addr[35:16] == 20'h0fec0
    |=> rsp_target == HMAD_TGT_IOIC) else $error("ioic miss");
  AST_TERM: assert property (req_valid && req_addr[35:32] != 4'h0
    |=> rsp_target == HMAD_TGT_TERM && rsp_drop_write == $past(req_write)
    && rsp_zero_data == !$past(req_write)) else $error("term");
  AST_HOLE: assert property (req_valid && req_addr[35:31] == 5'h01
    && req_addr < 36'h0fec00000 |=> rsp_target == HMAD_TGT_PCI) else $error("pci hole");
  AST_PCILO: assert property (lo && req_from_pci
    |=> rsp_target == HMAD_TGT_PCI) else $error("pci saw mgmt ram");
  AST_COMPAT: assert property (cpu_lo && !hi_r |=> rsp_target == HMAD_TGT_MEM
    && !rsp_cacheable && rsp_addr == $past(req_addr)) else $error("compat");
  AST_HIGH: assert property (cpu_lo && hi_r |=> rsp_target == HMAD_TGT_MEM
    && rsp_cacheable && rsp_addr == $past(req_addr) + 36'h010000000) else $error("high");
endmodule // hmad_chk

// ### hmad_decoder.sv
/*
 * host memory address decoder: steers each memory request to main memory,
 * pci, bios, the interrupt-controller window or local termination.
 * assumes: one request per valid cycle from the processor bus or a pci/isa
 * master; answer registered one cycle later.
 */
// How it works
// - top 2 MB below 4 GB goes to the bios target, not memory.
// - bios window decodes from reset, so first fetches reach bios.
// - 0fec00000h-0fec0ffffh goes to the interrupt-controller window.
// - extended mgmt ram is top 2MB of memory, below 256MB, at its own address.
// - extended mgmt ram enabled caps top of memory at 256MB.
// - 4 GB to 64 GB claimed locally; writes dropped, reads return zero.
// - while copying, reads go to rom, writes go to ram.
// - once shadowed, reads come from ram, writes go to rom side.
// - pci/isa accesses to shadowed blocks never reach the processor bus.
// - mgmt ram visible only in management state or when configured open.
// - compatible mgmt ram is a0000h-bffffh main memory, non-cacheable.
// - high mgmt ram lies above 256MB, write-back cacheable, aliased low.
// - mgmt ram type and place come from the register at 73h; 72h sets visibility.
// - unclaimed 2 GB to 4 GB addresses are forwarded to pci.
// - memory above 1 MB up to installed top (max 2 GB) is main memory.
`timescale 1ns/1ps
`include "hmad_params.svh"
module hmad_decoder
  import hmad_pkg::*;
#(
  parameter int NBLK = 16
) (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                req_valid,
  input  wire logic [35:0]         req_addr,
  input  wire logic                req_write,
  input  wire logic                req_from_pci,
  input  wire logic                system_management_state,
  input  wire logic [35:0]         mem_top,
  input  wire logic [2*NBLK-1:0]   shadow_attr,
  input  wire logic                cfg_wr,
  input  wire logic [7:0]          cfg_addr,
  input  wire logic [7:0]          cfg_wdata,
  output logic                     cfg_rdata_valid,
  output logic [7:0]               cfg_rdata,
  output logic                     rsp_valid,
  output hmad_target_e             rsp_target,
  output logic [35:0]              rsp_addr,
  output logic                     rsp_cacheable,
  output logic                     rsp_zero_data,
  output logic                     rsp_drop_write,
  output logic                     rsp_host_snoop
);
  // ========================================================================
  // elaboration check: the shadow area holds at most 16 blocks of 16 KB
  if (NBLK < 1 || NBLK > 16) begin : g_bad_nblk
    $error("hmad_decoder: NBLK out of range");
  end

  // ========================================================================
  // all state in one record: config registers and the registered answer
  typedef struct packed {
    logic [7:0]   mrc;
    logic [7:0]   emrc;
    logic         cfg_rv;
    logic [7:0]   cfg_rd;
    logic         rv;
    hmad_target_e tgt;
    logic [35:0]  addr;
    logic         cach;
    logic         zero;
    logic         drop;
    logic         snoop;
  } hmad_state_s;

  hmad_state_s st_r;
  hmad_state_s st_nxt;

  logic       sh_in;
  hmad_attr_s sh_attr;

  // ========================================================================
  // shadow attribute lookup
  hmad_shadow_sel #(.NBLK(NBLK)) u_shadow (
    .attr_bits (shadow_attr),
    .addr      (req_addr),
    .in_area   (sh_in),
    .attr      (sh_attr)
  );

  // visibility of mgmt ram: management state, or opened and not locked
  function automatic logic mgmt_visible(input logic [7:0] mrc, input logic in_mgmt);
    mgmt_visible = in_mgmt || (mrc[`HMAD_MRC_OPEN_BIT] && !mrc[`HMAD_MRC_LOCK_BIT]);
  endfunction

  // compatible window a0000h-bffffh, tested by more than one branch below
  function automatic logic in_low_mgmt(input logic [35:0] a);
    in_low_mgmt = (a >= `HMAD_LOW_MGMT_BASE) && (a <= `HMAD_LOW_MGMT_LIMIT);
  endfunction

  logic [35:0] top_eff;
  logic [35:0] seg_base;
  logic        vis;
  logic        ext_en;
  logic        high_en;

  // ========================================================================
  // next state: config registers and one-cycle decode answer
  always_comb begin
    st_nxt        = st_r;
    st_nxt.cfg_rv = 1'b0;
    st_nxt.rv     = 1'b0;
    ext_en  = st_r.emrc[`HMAD_EMRC_TOP_BIT];
    high_en = st_r.emrc[`HMAD_EMRC_HIGH_BIT];
    vis     = mgmt_visible(st_r.mrc, system_management_state);
    // cap the top at 256MB with extended ram, else at the 2 GB physical top
    top_eff = (mem_top > `HMAD_PHYS_TOP_2GB) ? `HMAD_PHYS_TOP_2GB : mem_top;
    if (ext_en && top_eff > `HMAD_MEM_CAP_256MB) begin
      top_eff = `HMAD_MEM_CAP_256MB;
    end
    seg_base = top_eff - `HMAD_TOP_SEG_SIZE;

    // lock bit, once set, freezes the open bit until reset
    if (cfg_wr && cfg_addr == `HMAD_OFS_MGMT_RAM_CTL && !st_r.mrc[`HMAD_MRC_LOCK_BIT]) begin
      st_nxt.mrc = cfg_wdata;
    end else if (cfg_wr && cfg_addr == `HMAD_OFS_EXT_MGMT_RAM_CTL) begin
      st_nxt.emrc = cfg_wdata;
    end
    // reads answer every idle cycle; unmapped offsets read as zero
    if (!cfg_wr) begin
      st_nxt.cfg_rv = 1'b1;
      st_nxt.cfg_rd = (cfg_addr == `HMAD_OFS_MGMT_RAM_CTL) ? st_r.mrc :
                      (cfg_addr == `HMAD_OFS_EXT_MGMT_RAM_CTL) ? st_r.emrc : 8'h00;
    end

    // decode: rv drops between requests; the other answer fields keep their last value
    if (req_valid) begin
      st_nxt.rv    = 1'b1;
      st_nxt.addr  = req_addr;
      st_nxt.cach  = 1'b1;
      st_nxt.zero  = 1'b0;
      st_nxt.drop  = 1'b0;
      st_nxt.snoop = !req_from_pci;
      // priority chain: one target, windows first
      if (req_addr >= `HMAD_FOUR_GB) begin
        st_nxt.tgt  = HMAD_TGT_TERM;
        st_nxt.zero = !req_write;
        st_nxt.drop = req_write;
      end else if (req_addr >= `HMAD_BIOS_BASE) begin
        // no enable gates this window, so boot fetches hit it from reset
        st_nxt.tgt  = HMAD_TGT_BIOS;
        st_nxt.cach = 1'b0;
      end else if (req_addr >= `HMAD_IOIC_BASE && req_addr <= `HMAD_IOIC_LIMIT) begin
        st_nxt.tgt  = HMAD_TGT_IOIC;
        st_nxt.cach = 1'b0;
      end else if (req_addr >= `HMAD_PHYS_TOP_2GB) begin
        st_nxt.tgt  = HMAD_TGT_PCI;
        st_nxt.cach = 1'b0;
      end else if (in_low_mgmt(req_addr) && vis && !req_from_pci) begin
        st_nxt.tgt = HMAD_TGT_MEM;
        if (high_en) begin
          st_nxt.addr = req_addr + `HMAD_MEM_CAP_256MB;
        end else begin
          st_nxt.cach = 1'b0;
        end
      end else if (req_addr >= `HMAD_LOW_MGMT_BASE && req_addr <= `HMAD_HIGH_ALIAS_LIMIT
                   && high_en && vis && !req_from_pci) begin
        st_nxt.tgt  = HMAD_TGT_MEM;
        st_nxt.addr = req_addr + `HMAD_MEM_CAP_256MB;
      end else if (in_low_mgmt(req_addr)) begin
        // hidden window falls through to the video side of pci
        st_nxt.tgt  = HMAD_TGT_PCI;
        st_nxt.cach = 1'b0;
      end else if (sh_in) begin
        // re/we set the ram side; cleared side falls to rom on pci
        if (req_write) begin
          st_nxt.tgt = sh_attr.we ? HMAD_TGT_MEM : HMAD_TGT_PCI;
        end else begin
          st_nxt.tgt = sh_attr.re ? HMAD_TGT_MEM : HMAD_TGT_PCI;
        end
        if (req_from_pci && sh_attr.re) begin
          st_nxt.snoop = 1'b0;
        end
        st_nxt.cach = (st_nxt.tgt == HMAD_TGT_MEM);
      end else if (req_addr < `HMAD_ONE_MB) begin
        st_nxt.tgt  = (req_addr < `HMAD_LOW_MGMT_BASE) ? HMAD_TGT_MEM : HMAD_TGT_PCI;
      end else if (ext_en && req_addr >= seg_base && req_addr < top_eff) begin
        // the top segment itself is hidden unless in management state or opened and not locked
        st_nxt.tgt  = vis ? HMAD_TGT_MEM : HMAD_TGT_PCI;
      end else if (req_addr < top_eff) begin
        st_nxt.tgt  = HMAD_TGT_MEM;
      end else begin
        st_nxt.tgt  = HMAD_TGT_PCI;
        st_nxt.cach = 1'b0;
      end
    end
  end

  // ========================================================================
  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r      <= '0;
      st_r.mrc  <= `HMAD_MGMT_RAM_CTL_RST;
      st_r.emrc <= `HMAD_EXT_MGMT_RAM_CTL_RST;
      st_r.tgt  <= HMAD_TGT_NONE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ========================================================================
  // outputs straight from the state register
  assign cfg_rdata_valid = st_r.cfg_rv;
  assign cfg_rdata       = st_r.cfg_rd;
  assign rsp_valid       = st_r.rv;
  assign rsp_target      = st_r.tgt;
  assign rsp_addr        = st_r.addr;
  assign rsp_cacheable   = st_r.cach;
  assign rsp_zero_data   = st_r.zero;
  assign rsp_drop_write  = st_r.drop;
  assign rsp_host_snoop  = st_r.snoop;
endmodule // hmad_decoder

// ### hmad_host_model.sv
/* request model of the processor bus and pci/isa masters.
   assumes: tb calls issue(), one request per call. */
`timescale 1ns/1ps
module hmad_host_model (
  input  wire logic   clk,
  output logic        req_valid,
  output logic [35:0] req_addr,
  output logic        req_write,
  output logic        req_from_pci
);
  // ==========================================================================
  // one request: launched after an edge, held through the taking edge
  initial req_valid = 1'b0;
  task automatic issue(input logic [35:0] a, input logic w, input logic p);
    @(posedge clk);
    #1;
    req_valid = 1'b1;
    req_addr = a;
    req_write = w;
    req_from_pci = p;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    req_addr = ~a; // released: a stale address must not look like a request
  endtask
endmodule // hmad_host_model

// ### hmad_params.svh
/*
 * constants for the host memory address decoder: window bounds, register
 * offsets, reset values and field positions.
 * assumes: included by the package and the decoder; definitions only.
 */
`ifndef HMAD_PARAMS_SVH
`define HMAD_PARAMS_SVH

// ==========================================================================
// register offsets in configuration space and their reset values
`define HMAD_OFS_MGMT_RAM_CTL     8'h72
`define HMAD_OFS_EXT_MGMT_RAM_CTL 8'h73
`define HMAD_MGMT_RAM_CTL_RST     8'h02
`define HMAD_EXT_MGMT_RAM_CTL_RST 8'h00

// ==========================================================================
// mgmt_ram_control fields
`define HMAD_MRC_OPEN_BIT   6
`define HMAD_MRC_CLOSE_BIT  5
`define HMAD_MRC_LOCK_BIT   4
`define HMAD_MRC_GLOBAL_BIT 3
// extended_mgmt_ram_control fields
`define HMAD_EMRC_HIGH_BIT  7
`define HMAD_EMRC_TOP_BIT   0

// ==========================================================================
// address windows, 36-bit physical address
`define HMAD_ONE_MB          36'h0_0010_0000
`define HMAD_LOW_MGMT_BASE   36'h0_000a_0000
`define HMAD_LOW_MGMT_LIMIT  36'h0_000b_ffff
`define HMAD_HIGH_ALIAS_LIMIT 36'h0_000f_ffff
`define HMAD_MEM_CAP_256MB   36'h0_1000_0000
`define HMAD_PHYS_TOP_2GB    36'h0_8000_0000
`define HMAD_FOUR_GB         36'h1_0000_0000
`define HMAD_BIOS_BASE       36'h0_ffe0_0000
`define HMAD_IOIC_BASE       36'h0_fec0_0000
`define HMAD_IOIC_LIMIT      36'h0_fec0_ffff
`define HMAD_TOP_SEG_SIZE    36'h0_0020_0000
`define HMAD_SHADOW_BASE     36'h0_000c_0000

`endif

// ### hmad_pkg.sv
/*
 * types for the host memory address decoder.
 * assumes: hmad_params.svh in the include path.
 */
package hmad_pkg;
  `include "hmad_params.svh"

  // ========================================================================
  // decode targets
  typedef enum logic [2:0] {
    HMAD_TGT_MEM,
    HMAD_TGT_PCI,
    HMAD_TGT_BIOS,
    HMAD_TGT_IOIC,
    HMAD_TGT_TERM,
    HMAD_TGT_NONE
  } hmad_target_e;

  // per-block shadow attribute: read enable, write enable toward ram
  typedef struct packed {
    logic re;
    logic we;
  } hmad_attr_s;
endpackage

// ### hmad_shadow_sel.sv
/*
 * per-block shadow attribute lookup for the 0c0000h-0fffffh area.
 * assumes: attributes packed two bits per 16 KB block, block 0 lowest.
 */
`timescale 1ns/1ps
`include "hmad_params.svh"
module hmad_shadow_sel
  import hmad_pkg::*;
#(
  parameter int NBLK = 16
) (
  input  wire logic [2*NBLK-1:0] attr_bits,
  input  wire logic [35:0]       addr,
  output logic                   in_area,
  output hmad_attr_s             attr
);
  // elaboration check: index is four bits wide, so at most 16 blocks
  if (NBLK < 1 || NBLK > 16) begin : g_bad_nblk
    $error("hmad_shadow_sel: NBLK out of range");
  end

  logic [35:0] off;

  // ========================================================================
  // block index from address; 16 KB granularity
  always_comb begin
    off     = addr - `HMAD_SHADOW_BASE;
    in_area = (addr >= `HMAD_SHADOW_BASE) && (off[35:14] < 22'(NBLK));
    attr    = '0;
    if (in_area) begin
      attr = hmad_attr_s'(attr_bits[2*off[17:14] +: 2]);
    end
  end
endmodule // hmad_shadow_sel

// ### tb.sv
/* self-checking bench for hmad_decoder.
   assumes: answers come one cycle after each request. */
`timescale 1ns/1ps
module tb;
  import hmad_pkg::*;
  // ==========================================================================
  // signals
  logic         clk, rst, req_valid, req_write, req_from_pci, cfg_wr, cfg_rdata_valid;
  logic         system_management_state, rsp_valid, rsp_cacheable, rsp_zero_data;
  logic         rsp_drop_write, rsp_host_snoop;
  logic [7:0]   cfg_addr, cfg_wdata, cfg_rdata;
  logic [35:0]  req_addr, mem_top, rsp_addr;
  logic [31:0]  shadow_attr;
  hmad_target_e rsp_target;
  int           err_total, check_count;
  hmad_host_model host (.clk, .req_valid, .req_addr, .req_write, .req_from_pci);
  hmad_decoder dut (.clk, .rst, .req_valid, .req_addr, .req_write, .req_from_pci,
    .system_management_state, .mem_top, .shadow_attr, .cfg_wr, .cfg_addr, .cfg_wdata,
    .cfg_rdata_valid, .cfg_rdata, .rsp_valid, .rsp_target, .rsp_addr, .rsp_cacheable,
    .rsp_zero_data, .rsp_drop_write, .rsp_host_snoop);
  // ==========================================================================
  // shared tasks
  task automatic cmp(input logic [35:0] got, input logic [35:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk(input logic [35:0] a, input logic w, p, input hmad_target_e t);
    host.issue(a, w, p);
    cmp(36'(rsp_valid), 36'h1);
    cmp(36'(rsp_target), 36'(t));
  endtask
  task automatic cfg_w(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    @(posedge clk);
    #1;
    cfg_wr = 1'b0;
  endtask
  task automatic cfg_rd(input logic [7:0] a, input logic [7:0] exp);
    cfg_addr = a;
    @(posedge clk);
    #1;
    cmp(36'(cfg_rdata_valid), 36'h1);
    cmp(36'(cfg_rdata), 36'(exp));
  endtask
  task automatic report_and_stop();
    if (err_total == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================================================
  // scenarios
  task automatic sc_boot();
    chk(36'h0fff00000, 0, 0, HMAD_TGT_BIOS);
    cmp(36'(rsp_cacheable), 36'h0);
    chk(36'h0ffe00000, 0, 0, HMAD_TGT_BIOS);
    chk(36'h0ffdfffff, 0, 0, HMAD_TGT_PCI);
    cfg_rd(8'h72, 8'h02);
    cfg_rd(8'h73, 8'h00);
    cfg_rd(8'h10, 8'h00);
  endtask
  task automatic sc_win();
    chk(36'h0fec00000, 0, 0, HMAD_TGT_IOIC);
    chk(36'h0fec0ffff, 1, 0, HMAD_TGT_IOIC);
    chk(36'h0fec10000, 0, 0, HMAD_TGT_PCI);
    chk(36'h100000000, 0, 0, HMAD_TGT_TERM);
    cmp(36'(rsp_zero_data), 36'h1);
    chk(36'hffffffff0, 1, 0, HMAD_TGT_TERM);
    cmp(36'(rsp_drop_write), 36'h1);
  endtask
  task automatic sc_mem();
    chk(36'h00009ffff, 0, 0, HMAD_TGT_MEM);
    chk(36'h000100000, 1, 0, HMAD_TGT_MEM);
    chk(36'h03fffffff, 0, 0, HMAD_TGT_MEM);
    chk(36'h040000000, 0, 0, HMAD_TGT_PCI);
    cfg_w(8'h73, 8'h01);
    chk(36'h010000000, 0, 0, HMAD_TGT_PCI);
    chk(36'h00fe00000, 0, 0, HMAD_TGT_PCI);
    system_management_state = 1'b1;
    chk(36'h00fe00000, 0, 0, HMAD_TGT_MEM);
    system_management_state = 1'b0;
    cfg_w(8'h73, 8'h00);
  endtask
  task automatic sc_shadow();
    shadow_attr = 32'h1; // copying: write-to-ram only
    chk(36'h0000c0000, 0, 0, HMAD_TGT_PCI);
    chk(36'h0000c0000, 1, 0, HMAD_TGT_MEM);
    shadow_attr = 32'h2; // shadowed: read-from-ram only
    chk(36'h0000c0000, 0, 0, HMAD_TGT_MEM);
    cmp(36'(rsp_host_snoop), 36'h1);
    chk(36'h0000c0000, 1, 0, HMAD_TGT_PCI);
    host.issue(36'h0000c0000, 0, 1);
    cmp(36'(rsp_host_snoop), 36'h0);
  endtask
  task automatic sc_mgmt();
    chk(36'h0000a0000, 0, 0, HMAD_TGT_PCI);
    system_management_state = 1'b1;
    chk(36'h0000a0000, 0, 0, HMAD_TGT_MEM);
    chk(36'h0000a0000, 0, 1, HMAD_TGT_PCI);
    cfg_w(8'h73, 8'h80);
    chk(36'h0000bfff0, 0, 0, HMAD_TGT_MEM);
    cmp(rsp_addr, 36'h0100bfff0);
    system_management_state = 1'b0;
    cfg_w(8'h72, 8'h40);
    chk(36'h0000a0000, 0, 0, HMAD_TGT_MEM);
    cfg_w(8'h72, 8'h10);
    cfg_w(8'h72, 8'h40); // refused while locked
    cfg_rd(8'h72, 8'h10);
    chk(36'h0000a0000, 0, 0, HMAD_TGT_PCI);
  endtask
  // ==========================================================================
  // clock, reset, sequence and hang guard
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    {rst, system_management_state, cfg_wr, cfg_addr, cfg_wdata} = {3'h4, 16'h0};
    mem_top = 36'h040000000;
    shadow_attr = 32'h0;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    sc_boot();
    sc_win();
    sc_mem();
    sc_shadow();
    sc_mgmt();
    report_and_stop();
  end
  initial begin
    repeat (4000) @(posedge clk);
    err_total++;
    report_and_stop();
  end
endmodule // tb
bind hmad_decoder hmad_chk chk (.clk, .rst, .req_valid, .req_addr, .req_write, .req_from_pci,
  .system_management_state, .cfg_wr, .cfg_addr, .cfg_wdata, .rsp_valid, .rsp_target,
  .rsp_addr, .rsp_cacheable, .rsp_zero_data, .rsp_drop_write);
